// ---- core/pwrmon_defines.svh ----
// Purpose: register indices, field positions, reset values and counts of the alert logic
// Assumes: byte address of a register is four times its index
// Notes: definitions only
`ifndef PWRMON_DEFINES_SVH
`define PWRMON_DEFINES_SVH

// register indices
`define IDX_CONFIG     5'h00
`define IDX_SHUNT_BASE 5'h01
`define IDX_BUS_BASE   5'h02
`define IDX_CRIT_BASE  5'h07
`define IDX_WARN_BASE  5'h08
`define IDX_SUM        5'h0D
`define IDX_SUM_LIMIT  5'h0E
`define IDX_MASK_EN    5'h0F
`define IDX_PV_UPPER   5'h10
`define IDX_PV_LOWER   5'h11
`define IDX_PIN_STATE  5'h12
`define IDX_LAST       5'h12

// configuration fields
`define CFG_RESET_BIT  15
`define CFG_AVG_MSB    11
`define CFG_AVG_LSB    9
`define CFG_MODE_MSB   2
`define MODE_CONT_BOTH 3'h7

// mask and enable fields, channel 1 at the highest bit of each group
`define ME_SCC_MSB     14
`define ME_CF_MSB      9
`define ME_SF_BIT      6
`define ME_WF_MSB      5
`define ME_PVF_BIT     1
`define ME_TCF_BIT     0
`define ME_WR_MASK     16'h7000

// reset values
`define CONFIG_RST     16'h7127
`define LIMIT_RST      16'h7FF8
`define PV_UPPER_RST   16'h2710
`define PV_LOWER_RST   16'h2328
`define ZERO16         16'h0000

// sequencing check
`define TC_LEVEL       16'h04B0
`define TC_CYCLES      3'h4

`endif

// ---- core/pwrmon_pkg.sv ----
// Purpose: shared types of the alert logic
// Assumes: constants live in pwrmon_defines.svh
// Notes: samples are signed two's complement words
package pwrmon_pkg;

  typedef logic signed [15:0] sample_t;

  typedef enum logic [0:0] {
    PV_WAIT = 1'b0,
    PV_GOOD = 1'b1
  } pv_state_t;

  typedef enum logic [2:0] {
    TC_WAIT1 = 3'b000,
    TC_WAIT2 = 3'b001,
    TC_PASS  = 3'b010,
    TC_FAIL  = 3'b011,
    TC_OFF   = 3'b100
  } tc_state_t;

endpackage : pwrmon_pkg

// ---- core/power_monitor_alert_logic.sv ----
// Purpose: limit checks, averaging, power good and sequencing alerts of a 3-channel monitor
// Assumes: one conversion result per CONV_VALID pulse from the sequencer, APB register access
// Notes: alert pins are open drain; each only pulls low or releases
`timescale 1ns/1ps
`default_nettype none
`include "pwrmon_defines.svh"

// Overview of operation
// - all four alert pins are open drain: pull low or release
// - each single shunt conversion above its critical limit pulls critical low
// - critical and warning limits reset to positive full scale
// - per-channel critical flag is readable in mask and enable register
// - selected shunt conversions are summed; sum above limit pulls critical low
// - summation select bits disable summation or pick two or three channels
// - summation overrun has its own flag, apart from channel flags
// - each shunt conversion updates that channel's averaged shunt register
// - averaged shunt above warning limit pulls warning low
// - per-channel warning flag is readable in mask and enable register
// - power good starts low, releases when all buses reach upper limit
// - in good state any bus below lower limit pulls power good low
// - power good evaluated once all three buses converted, then on each refresh
// - bus register holds until a new bus conversion on that channel
// - channel 1 bus checked for 1.2 V on each pass in default mode
// - channel 2 not at 1.2 V within four cycles pulls timing low
// - sequencing check runs only after power-up or software reset
// - config write before sequencing completes disables timing alert
// - average adds difference over averaging count to previous value
// - software reset restores defaults but keeps power good state
module power_monitor_alert_logic
  import pwrmon_pkg::*;
(
  input  wire logic                CLK,
  input  wire logic                RST_N,
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [7:0]          PADDR,
  input  wire logic [31:0]         PWDATA,
  output logic      [31:0]         PRDATA,
  output logic                     PREADY,
  output logic                     PSLVERR,
  input  wire logic                CONV_VALID,
  input  wire logic [1:0]          CONV_CHANNEL,
  input  wire logic                CONV_BUS,
  input  wire pwrmon_pkg::sample_t CONV_DATA,
  input  wire logic                CRIT_I,
  output logic                     CRIT_O,
  output logic                     CRIT_OE_N,
  input  wire logic                WARN_I,
  output logic                     WARN_O,
  output logic                     WARN_OE_N,
  input  wire logic                POWER_GOOD_OUTPUT_I,
  output logic                     POWER_GOOD_OUTPUT_O,
  output logic                     POWER_GOOD_OUTPUT_OE_N,
  input  wire logic                TIMING_I,
  output logic                     TIMING_O,
  output logic                     TIMING_OE_N
);
  import pwrmon_pkg::*;

  localparam int NCH = 3;

  logic [4:0]     idx;
  logic           addr_ok;
  logic           wr_en;
  logic           rd_me;
  logic           cfg_wr;
  logic           soft_rst;
  logic [15:0]    config_q;
  sample_t        crit_q  [NCH];
  sample_t        warn_q  [NCH];
  sample_t        shunt_q [NCH];
  sample_t        bus_q   [NCH];
  sample_t        last_q  [NCH];
  sample_t        sum_q;
  sample_t        sum_limit_q;
  sample_t        pv_upper_q;
  sample_t        pv_lower_q;
  logic [2:0]     scc_q;
  logic [NCH-1:0] crit_flag_q;
  logic           sum_flag_q;
  logic [NCH-1:0] warn_live;
  logic [NCH-1:0] crit_hit;
  logic           sum_hit;
  logic           sum_en;
  logic signed [17:0] sum_wide;
  logic           conv_ok;
  logic           shunt_conv;
  logic           bus_conv;
  logic [NCH-1:0] bus_seen_q;
  logic           bus_upd_q;
  logic           all_up;
  logic           any_down;
  pv_state_t      pv_q;
  tc_state_t      tc_q;
  logic [2:0]     tc_cnt_q;
  logic [15:0]    me_view;
  logic [31:0]    rd_mux;
  logic [31:0]    prdata_q;

  // average step: prev + (conv - prev) / 2^sh, result always lies between both operands
  function automatic sample_t avg_step(sample_t prev, sample_t conv, logic [2:0] sel);
    logic signed [16:0] diff;
    logic signed [16:0] step;
    logic signed [16:0] res;
    logic [3:0]         sh;
    diff = 17'(conv) - 17'(prev);
    case (sel)
      3'h0:    sh = 4'h0;
      3'h1:    sh = 4'h2;
      3'h2:    sh = 4'h4;
      3'h3:    sh = 4'h6;
      3'h4:    sh = 4'h7;
      3'h5:    sh = 4'h8;
      3'h6:    sh = 4'h9;
      default: sh = 4'hA;
    endcase
    step = diff >>> sh;
    res  = 17'(prev) + step;
    return res[15:0];
  endfunction : avg_step

  // sum saturates so a large total still reads as over the limit
  function automatic sample_t sat16(logic signed [17:0] v);
    if (v > 18'sh07FFF)
      return 16'h7FFF;
    else if (v < -18'sh08000)
      return 16'h8000;
    else
      return v[15:0];
  endfunction : sat16

  // apb decode; every access completes in one access cycle
  assign idx      = PADDR[6:2];
  assign addr_ok  = (PADDR[1:0] == 2'h0) && !PADDR[7] && (idx <= `IDX_LAST);
  assign wr_en    = PSEL && PENABLE && PWRITE && addr_ok;
  assign rd_me    = PSEL && PENABLE && !PWRITE && addr_ok && (idx == `IDX_MASK_EN);
  assign cfg_wr   = wr_en && (idx == `IDX_CONFIG);
  assign soft_rst = cfg_wr && PWDATA[`CFG_RESET_BIT];
  assign PREADY   = PENABLE;
  assign PSLVERR  = PSEL && PENABLE && !addr_ok;
  assign PRDATA   = prdata_q;

  // conversion strobes; channel code 3 is not a channel and is dropped
  assign conv_ok    = CONV_VALID && (CONV_CHANNEL != 2'h3);
  assign shunt_conv = conv_ok && !CONV_BUS;
  assign bus_conv   = conv_ok && CONV_BUS;

  // configuration; the reset bit self-clears
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
      config_q <= `CONFIG_RST;
    else if (soft_rst)
      config_q <= `CONFIG_RST;
    else if (cfg_wr)
      config_q <= {1'b0, PWDATA[14:0]};

  // critical, warning and sum limit registers return to full scale on either reset
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        crit_q[c] <= `LIMIT_RST;
        warn_q[c] <= `LIMIT_RST;
      end
      sum_limit_q <= `LIMIT_RST;
      pv_upper_q  <= `PV_UPPER_RST;
      pv_lower_q  <= `PV_LOWER_RST;
      scc_q       <= 3'h0;
    end
    else if (soft_rst)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        crit_q[c] <= `LIMIT_RST;
        warn_q[c] <= `LIMIT_RST;
      end
      sum_limit_q <= `LIMIT_RST;
      pv_upper_q  <= `PV_UPPER_RST;
      pv_lower_q  <= `PV_LOWER_RST;
      scc_q       <= 3'h0;
    end
    else if (wr_en)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        if (idx == 5'(`IDX_CRIT_BASE + 2 * c))
          crit_q[c] <= PWDATA[15:0];
        if (idx == 5'(`IDX_WARN_BASE + 2 * c))
          warn_q[c] <= PWDATA[15:0];
      end
      if (idx == `IDX_SUM_LIMIT)
        sum_limit_q <= PWDATA[15:0];
      if (idx == `IDX_PV_UPPER)
        pv_upper_q <= PWDATA[15:0];
      if (idx == `IDX_PV_LOWER)
        pv_lower_q <= PWDATA[15:0];
      if (idx == `IDX_MASK_EN)
        scc_q <= PWDATA[`ME_SCC_MSB -: 3];
    end

  // averaged results; a bus value is touched only by its own conversion
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        shunt_q[c] <= `ZERO16;
        bus_q[c]   <= `ZERO16;
        last_q[c]  <= `ZERO16;
      end
    end
    else if (soft_rst)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        shunt_q[c] <= `ZERO16;
        bus_q[c]   <= `ZERO16;
        last_q[c]  <= `ZERO16;
      end
    end
    else
    begin
      for (int c = 0; c < NCH; c++)
      begin
        if (shunt_conv && CONV_CHANNEL == 2'(c))
        begin
          shunt_q[c] <= avg_step(shunt_q[c], CONV_DATA,
                                 config_q[`CFG_AVG_MSB:`CFG_AVG_LSB]);
          last_q[c]  <= CONV_DATA;
        end
        if (bus_conv && CONV_CHANNEL == 2'(c))
          bus_q[c] <= avg_step(bus_q[c], CONV_DATA,
                               config_q[`CFG_AVG_MSB:`CFG_AVG_LSB]);
      end
    end

  // sum of selected single conversions, the fresh one substituted; fewer than two means off
  assign sum_en = (scc_q[2] & scc_q[1]) | (scc_q[2] & scc_q[0]) | (scc_q[1] & scc_q[0]);
  always_comb
  begin
    sum_wide = 18'sh0;
    for (int c = 0; c < NCH; c++)
      if (scc_q[NCH-1-c])
        sum_wide = sum_wide + 18'((shunt_conv && CONV_CHANNEL == 2'(c)) ? CONV_DATA : last_q[c]);
  end
  assign sum_hit = sum_en && shunt_conv && scc_q[NCH-1-CONV_CHANNEL]
                   && (sum_wide > 18'(sum_limit_q));

  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
      sum_q <= `ZERO16;
    else if (soft_rst)
      sum_q <= `ZERO16;
    else if (sum_en && shunt_conv)
      sum_q <= sat16(sum_wide);

  // limit comparisons; equality does not trip
  always_comb
    for (int c = 0; c < NCH; c++)
    begin
      crit_hit[c]  = shunt_conv && CONV_CHANNEL == 2'(c)
                     && (CONV_DATA > crit_q[c]);
      warn_live[c] = shunt_q[c] > warn_q[c];
    end

  // sticky flags clear on a read of mask/enable, only bits that read returned; set wins
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      crit_flag_q <= 3'h0;
      sum_flag_q  <= 1'b0;
    end
    else if (soft_rst)
    begin
      crit_flag_q <= 3'h0;
      sum_flag_q  <= 1'b0;
    end
    else
    begin
      for (int c = 0; c < NCH; c++)
        crit_flag_q[c] <= crit_hit[c]
                          | (crit_flag_q[c] & ~(rd_me & prdata_q[`ME_CF_MSB - c]));
      sum_flag_q <= sum_hit | (sum_flag_q & ~(rd_me & prdata_q[`ME_SF_BIT]));
    end

  // power good evaluation one cycle after a bus register refresh, once all three are fresh
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      bus_seen_q <= 3'h0;
      bus_upd_q  <= 1'b0;
    end
    else if (soft_rst)
    begin
      bus_seen_q <= 3'h0;
      bus_upd_q  <= 1'b0;
    end
    else
    begin
      bus_upd_q <= bus_conv;
      if (bus_conv)
        bus_seen_q[CONV_CHANNEL] <= 1'b1;
    end

  always_comb
  begin
    all_up   = 1'b1;
    any_down = 1'b0;
    for (int c = 0; c < NCH; c++)
    begin
      all_up   = all_up & (bus_q[c] >= pv_upper_q);
      any_down = any_down | (bus_q[c] < pv_lower_q);
    end
  end

  // power good state survives a software reset; only power-up clears it
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
      pv_q <= PV_WAIT;
    else if (bus_upd_q && (&bus_seen_q))
    begin
      unique case (pv_q)
        PV_WAIT: if (all_up) pv_q <= PV_GOOD;
        PV_GOOD: if (any_down) pv_q <= PV_WAIT;
      endcase
    end

  // sequencing check: counts channel 3 bus results as ends of full cycles
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      tc_q     <= TC_WAIT1;
      tc_cnt_q <= 3'h0;
    end
    else if (soft_rst)
    begin
      tc_q     <= TC_WAIT1;
      tc_cnt_q <= 3'h0;
    end
    else if (cfg_wr && (tc_q == TC_WAIT1 || tc_q == TC_WAIT2))
      tc_q <= TC_OFF;
    else if (bus_conv)
    begin
      unique case (tc_q)
        TC_WAIT1:
          if (CONV_CHANNEL == 2'h0 && config_q[`CFG_MODE_MSB:0] == `MODE_CONT_BOTH
              && CONV_DATA >= $signed(`TC_LEVEL))                     // signed: a negative rail never passes
          begin
            tc_q     <= TC_WAIT2;
            tc_cnt_q <= 3'h0;
          end
        TC_WAIT2:
          if (CONV_CHANNEL == 2'h1 && CONV_DATA >= $signed(`TC_LEVEL))
            tc_q <= TC_PASS;
          else if (CONV_CHANNEL == 2'h2)
          begin
            tc_cnt_q <= tc_cnt_q + 3'h1;
            if (tc_cnt_q + 3'h1 == `TC_CYCLES)
              tc_q <= TC_FAIL;
          end
        TC_PASS, TC_FAIL, TC_OFF: ;
        default: tc_q <= TC_OFF;
      endcase
    end

  // open-drain pins: data always low, enable low means pulling low
  assign CRIT_O              = 1'b0;
  assign WARN_O              = 1'b0;
  assign POWER_GOOD_OUTPUT_O = 1'b0;
  assign TIMING_O            = 1'b0;
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      CRIT_OE_N              <= 1'b1;
      WARN_OE_N              <= 1'b1;
      POWER_GOOD_OUTPUT_OE_N <= 1'b0;
      TIMING_OE_N            <= 1'b1;
    end
    else
    begin
      CRIT_OE_N              <= ~(|crit_flag_q | sum_flag_q);
      WARN_OE_N              <= ~(|warn_live);
      POWER_GOOD_OUTPUT_OE_N <= (pv_q == PV_GOOD);
      TIMING_OE_N            <= (tc_q != TC_FAIL);
    end

  // read view; channel 1 sits at the highest bit of each flag group
  always_comb
  begin
    me_view = 16'h0000;
    me_view[`ME_SCC_MSB -: 3] = scc_q;
    for (int c = 0; c < NCH; c++)
    begin
      me_view[`ME_CF_MSB - c] = crit_flag_q[c];
      me_view[`ME_WF_MSB - c] = warn_live[c];
    end
    me_view[`ME_SF_BIT]  = sum_flag_q;
    me_view[`ME_PVF_BIT] = (pv_q == PV_GOOD);
    me_view[`ME_TCF_BIT] = (tc_q == TC_FAIL);
    rd_mux = 32'h0;
    case (idx)
      `IDX_CONFIG:    rd_mux[15:0] = config_q;
      `IDX_SUM:       rd_mux[15:0] = sum_q;
      `IDX_SUM_LIMIT: rd_mux[15:0] = sum_limit_q;
      `IDX_MASK_EN:   rd_mux[15:0] = me_view;
      `IDX_PV_UPPER:  rd_mux[15:0] = pv_upper_q;
      `IDX_PV_LOWER:  rd_mux[15:0] = pv_lower_q;
      `IDX_PIN_STATE: rd_mux[3:0]  = {TIMING_I, POWER_GOOD_OUTPUT_I, WARN_I, CRIT_I};
      default:
        for (int c = 0; c < NCH; c++)
        begin
          if (idx == 5'(`IDX_SHUNT_BASE + 2 * c)) rd_mux[15:0] = shunt_q[c];
          if (idx == 5'(`IDX_BUS_BASE + 2 * c))   rd_mux[15:0] = bus_q[c];
          if (idx == 5'(`IDX_CRIT_BASE + 2 * c))  rd_mux[15:0] = crit_q[c];
          if (idx == 5'(`IDX_WARN_BASE + 2 * c))  rd_mux[15:0] = warn_q[c];
        end
    endcase
  end

  // read data captured in the setup cycle so a clear acts only on what was returned
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
      prdata_q <= 32'h0;
    else if (PSEL && !PENABLE && !PWRITE)
      prdata_q <= rd_mux;

  crit_pin_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (|crit_flag_q) |=> !CRIT_OE_N)
    else $error("critical flag set but pin not pulled low");
  crit_flag_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (crit_hit[0] && !soft_rst) |=> crit_flag_q[0] ##1 !CRIT_OE_N)
    else $error("critical conversion did not set flag and pin");
  strict_limit_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (shunt_conv && CONV_CHANNEL == 2'h0 && CONV_DATA == crit_q[0]) |-> !crit_hit[0])
    else $error("equal value counted as over critical limit");
  limit_default_a: assert property (@(posedge CLK) disable iff (!RST_N)
    soft_rst |=> (crit_q[1] == `LIMIT_RST && warn_q[2] == `LIMIT_RST))
    else $error("limit not full scale after software reset");
  sum_flag_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (sum_hit && !soft_rst) |=> sum_flag_q ##1 !CRIT_OE_N)
    else $error("sum over limit not flagged");
  bus_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (!bus_conv && !soft_rst) |=> $stable(bus_q[0]) && $stable(bus_q[1]) && $stable(bus_q[2]))
    else $error("bus value changed without a bus conversion");
  pv_state_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (pv_q == PV_WAIT) [*2] |-> !POWER_GOOD_OUTPUT_OE_N)
    else $error("power good released while waiting");
  pv_drop_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (pv_q == PV_GOOD && bus_upd_q && (&bus_seen_q) && any_down) |=> pv_q == PV_WAIT ##1
    !POWER_GOOD_OUTPUT_OE_N)
    else $error("rail drop did not pull power good low");
  tc_off_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (cfg_wr && !soft_rst && (tc_q == TC_WAIT1 || tc_q == TC_WAIT2)) |=> tc_q == TC_OFF)
    else $error("config write did not disable sequencing check");
  tc_fail_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (tc_q == TC_FAIL) |=> !TIMING_OE_N)
    else $error("timing pin not pulled low on failure");

endmodule : power_monitor_alert_logic
`default_nettype wire

// ---- tb/alert_pins.sv ----
// Purpose: board side of the four open-drain alert nets
// Assumes: a low output enable means the device pulls the net low
// Notes: a released net reads high through its pull-up, never the last driven level
`timescale 1ns/1ps
`default_nettype none
module alert_pins (
  input  wire logic [3:0] o,
  input  wire logic [3:0] oe_n,
  output logic      [3:0] lvl
);
  // pull-up wins whenever the device lets go, so a stuck driver shows up
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      lvl[i] = oe_n[i] ? 1'b1 : o[i];
    end
  end
endmodule : alert_pins
`default_nettype wire

// ---- tb/test_power_monitor_alert_logic.sv ----
// Purpose: directed bench of the alert logic through its APB port and result strobe
// Assumes: pin order crit, warn, power good, timing; averaging of one after reset
// Notes: pins are read through the pull-up model a few cycles after each cause
`timescale 1ns/1ps
`default_nettype none
module test_power_monitor_alert_logic;
  import pwrmon_pkg::*;
  logic        clk, rst_n, psel, pen, pwr, cv, cbus, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr;
  logic [1:0]  cch;
  sample_t     cdata;
  logic [15:0] r;
  wire  [3:0]  o, oe_n, lvl;
  int          n_errors, n_checks;

  power_monitor_alert_logic uut (
    .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CONV_VALID(cv), .CONV_CHANNEL(cch), .CONV_BUS(cbus), .CONV_DATA(cdata),
    .CRIT_I(lvl[0]), .CRIT_O(o[0]), .CRIT_OE_N(oe_n[0]),
    .WARN_I(lvl[1]), .WARN_O(o[1]), .WARN_OE_N(oe_n[1]),
    .POWER_GOOD_OUTPUT_I(lvl[2]), .POWER_GOOD_OUTPUT_O(o[2]),
    .POWER_GOOD_OUTPUT_OE_N(oe_n[2]),
    .TIMING_I(lvl[3]), .TIMING_O(o[3]), .TIMING_OE_N(oe_n[3])
  );
  alert_pins pins (.o(o), .oe_n(oe_n), .lvl(lvl));

  // free-running 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // compare, count and report a mismatch at once
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  // one APB transfer, held until pready is sampled high; read data taken there
  task automatic apb(input logic w, input logic [4:0] idx, input logic [15:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= {1'b0, idx, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata[15:0];
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  task automatic rdchk(input string nm, input logic [4:0] idx, input logic [15:0] m,
                       input logic [15:0] e);
    apb(1'b0, idx, 16'h0000);
    chk(nm, r & m, e);
  endtask : rdchk

  // one result strobe; data is scrambled afterwards so stale data never matches
  task automatic conv(input logic b, input logic [1:0] ch, input logic [15:0] d);
    @(posedge clk);
    cv    <= 1'b1;
    cbus  <= b;
    cch   <= ch;
    cdata <= d;
    @(posedge clk);
    cv    <= 1'b0;
    cdata <= ~d;
    repeat (2) @(posedge clk);
  endtask : conv

  // pins lag their cause by up to three cycles
  task automatic pin(input string nm, input int i, input logic e);
    repeat (3) @(posedge clk);
    #1;
    chk(nm, {15'h0000, lvl[i]}, {15'h0000, e});
  endtask : pin

  // rounds of channel 2 below the sequencing level, channel 3 bus closing each
  task automatic tc_round(input int n);
    repeat (n)
    begin
      conv(1'b1, 2'd1, 16'h04AF);
      conv(1'b1, 2'd2, 16'h0100);
    end
  endtask : tc_round

  // bounded run; a hang ends in the common verdict
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    test_done();
  end

  initial
  begin
    n_errors = 0;
    n_checks = 0;
    rst_n = 1'b0;
    {psel, pen, pwr, cv, cbus, cch} = '0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    cdata = 16'h0000;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rdchk("config", 5'h00, 16'hFFFF, 16'h7127);
    rdchk("crit limit", 5'h07, 16'hFFFF, 16'h7FF8);
    rdchk("warn limit", 5'h0C, 16'hFFFF, 16'h7FF8);
    rdchk("pv upper", 5'h10, 16'hFFFF, 16'h2710);
    rdchk("pv lower", 5'h11, 16'hFFFF, 16'h2328);
    rdchk("pin state", 5'h12, 16'h000F, 16'h000B);
    apb(1'b0, 5'h1F, 16'h0000);
    chk("unmapped", {15'h0000, err}, 16'h0001);
    $display("test reset done");
    conv(1'b1, 2'd0, 16'h04B0);
    tc_round(3);
    pin("timing early", 3, 1'b1);
    tc_round(1);
    pin("timing late", 3, 1'b0);
    rdchk("timing flag", 5'h0F, 16'h0001, 16'h0001);
    $display("test sequencing done");
    apb(1'b1, 5'h07, 16'h0100);
    conv(1'b0, 2'd0, 16'h0100);
    pin("crit equal", 0, 1'b1);
    conv(1'b0, 2'd0, 16'h0101);
    pin("crit over", 0, 1'b0);
    rdchk("crit flags", 5'h0F, 16'h0380, 16'h0200);
    rdchk("shunt ch1", 5'h01, 16'hFFFF, 16'h0101);
    apb(1'b1, 5'h08, 16'h0080);
    conv(1'b0, 2'd0, 16'h0101);
    pin("warn", 1, 1'b0);
    rdchk("warn flags", 5'h0F, 16'h0038, 16'h0020);
    apb(1'b1, 5'h00, 16'h7327);
    conv(1'b0, 2'd0, 16'h0201);
    rdchk("average", 5'h01, 16'hFFFF, 16'h0141);
    apb(1'b1, 5'h0E, 16'h0150);
    apb(1'b1, 5'h0F, 16'h4000);
    conv(1'b0, 2'd1, 16'h0060);
    rdchk("sum off", 5'h0F, 16'h0040, 16'h0000);
    apb(1'b1, 5'h0F, 16'h6000);
    conv(1'b0, 2'd1, 16'h0060);
    rdchk("sum two", 5'h0D, 16'hFFFF, 16'h0261);
    rdchk("sum flag", 5'h0F, 16'h0040, 16'h0040);
    apb(1'b1, 5'h0F, 16'h7000);
    conv(1'b0, 2'd2, 16'h0010);
    rdchk("sum three", 5'h0D, 16'hFFFF, 16'h0271);
    $display("test limits done");
    apb(1'b1, 5'h00, 16'h7127);
    conv(1'b1, 2'd0, 16'h2710);
    conv(1'b1, 2'd1, 16'h2710);
    pin("pg two rails", 2, 1'b0);
    conv(1'b1, 2'd2, 16'h2710);
    pin("pg all rails", 2, 1'b1);
    conv(1'b1, 2'd1, 16'h2328);
    pin("pg at lower", 2, 1'b1);
    conv(1'b1, 2'd1, 16'h2327);
    pin("pg below", 2, 1'b0);
    rdchk("bus ch1 held", 5'h02, 16'hFFFF, 16'h2710);
    conv(1'b1, 2'd1, 16'h2710);
    pin("pg again", 2, 1'b1);
    $display("test power good done");
    apb(1'b1, 5'h00, 16'hF127);
    pin("pg kept", 2, 1'b1);
    pin("timing released", 3, 1'b1);
    pin("crit released", 0, 1'b1);
    rdchk("limit restored", 5'h07, 16'hFFFF, 16'h7FF8);
    conv(1'b1, 2'd0, 16'h04B0);
    pin("pg one rail", 2, 1'b1);
    tc_round(4);
    pin("timing rerun", 3, 1'b0);
    apb(1'b1, 5'h00, 16'hF127);
    apb(1'b1, 5'h00, 16'h7127);
    conv(1'b1, 2'd0, 16'h04B0);
    tc_round(4);
    pin("timing disabled", 3, 1'b1);
    apb(1'b1, 5'h00, 16'hF127);
    conv(1'b1, 2'd0, 16'h04B0);
    apb(1'b1, 5'h00, 16'h7127);
    tc_round(4);
    pin("timing cut late", 3, 1'b1);
    $display("test software reset done");
    test_done();
  end
endmodule : test_power_monitor_alert_logic
`default_nettype wire
